/* File: vtsi_pkg.sv */
// Constants and types of the vacuum terminal status image
package vtsi_pkg;
    localparam int unsigned NUM_SUCT = 16;
    localparam int unsigned NUM_PORT = 8;
    localparam int unsigned PORT_LEN = 32;
    localparam int unsigned SYNC_STAGES = 2;

    localparam logic [8:0] OFS_HEALTH = 9'h000;
    localparam logic [8:0] OFS_FAULT = 9'h001;
    localparam logic [8:0] OFS_WARN = 9'h002;
    localparam logic [8:0] OFS_SUCT = 9'h003;
    localparam logic [8:0] OFS_AIR = 9'h013;
    localparam logic [8:0] OFS_PORT = 9'h017;
    localparam logic [8:0] OFS_PORT_END = 9'h117;
    localparam logic [8:0] IMG_END = 9'h1bd;

    localparam int unsigned FLT_CORRUPT = 0;
    localparam int unsigned FLT_BUS = 1;
    localparam int unsigned FLT_PRI_LO = 2;
    localparam int unsigned FLT_PRI_HI = 3;
    localparam int unsigned FLT_SEC_LO = 4;
    localparam int unsigned FLT_SEC_HI = 5;
    localparam int unsigned FLT_PRESS = 6;
    localparam int unsigned FLT_SUCT = 7;

    localparam int unsigned WRN_PRI = 0;
    localparam int unsigned WRN_SEC = 1;
    localparam int unsigned WRN_PRESS = 2;
    localparam int unsigned WRN_SUCT = 3;

    localparam int unsigned ST_AIR_SAVE = 0;
    localparam int unsigned ST_PART = 1;
    localparam int unsigned ST_FLAGS_LSB = 2;
    localparam int unsigned ST_FLAGS_W = 6;

    localparam logic [1:0] HL_OPTIMAL = 2'h0;
    localparam logic [1:0] HL_MAINT = 2'h1;
    localparam logic [1:0] HL_WARN = 2'h2;

    // Pressures in 0.1 bar steps
    localparam logic [7:0] PRESS_ERR_MIN = 8'h13;
    localparam logic [7:0] PRESS_ERR_MAX = 8'h3f;
    localparam logic [7:0] PRESS_WRN_MIN = 8'h23;
    localparam logic [7:0] PRESS_WRN_MAX = 8'h32;
    localparam logic [7:0] PRESS_HYST = 8'h02;

    localparam logic [7:0] BYTE_RST = 8'h00;
    localparam logic [31:0] AIR_RST = 32'h0000_0000;

    typedef enum logic [1:0] {
        PM_OFF = 2'b00,
        PM_IOLINK = 2'b01,
        PM_DI = 2'b10,
        PM_DO = 2'b11
    } vtsi_port_mode_e;
endpackage

/* File: vtsi_press_if.sv */
// Supply pressure and its limit flags between core and monitor
`timescale 1ns/1ps
interface vtsi_press_if;
    logic [7:0] pressure;
    logic err;
    logic warn;
    modport mon (input pressure, output err, output warn);
    modport core (output pressure, input err, input warn);
endinterface

/* File: vtsi_sync.sv */
// Two-flop synchroniser bank for pin inputs
`timescale 1ns/1ps
module vtsi_sync #(
    parameter int unsigned W = 8
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_r;

    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            always_ff @(posedge clk or negedge rst_b) begin
                if (!rst_b) begin
                    meta_r[i] <= 1'b0;
                    q[i] <= 1'b0;
                end else begin
                    meta_r[i] <= d[i];
                    q[i] <= meta_r[i];
                end
            end
        end
    endgenerate
endmodule // vtsi_sync

/* File: vtsi_press_mon.sv */
// Supply pressure error window and warning with hysteresis
`timescale 1ns/1ps
module vtsi_press_mon (
    input wire logic clk,
    input wire logic rst_b,
    vtsi_press_if.mon bus
);
    localparam logic [7:0] CLR_LO = 8'(vtsi_pkg::PRESS_WRN_MIN + vtsi_pkg::PRESS_HYST);
    localparam logic [7:0] CLR_HI = 8'(vtsi_pkg::PRESS_WRN_MAX - vtsi_pkg::PRESS_HYST);

    logic warn_r;
    wire out_wrn = (bus.pressure < vtsi_pkg::PRESS_WRN_MIN) || (bus.pressure > vtsi_pkg::PRESS_WRN_MAX);
    wire back_in = (bus.pressure >= CLR_LO) && (bus.pressure <= CLR_HI);
    wire warn_nxt = out_wrn ? 1'b1 : (back_in ? 1'b0 : warn_r);

    assign bus.err = (bus.pressure < vtsi_pkg::PRESS_ERR_MIN) || (bus.pressure > vtsi_pkg::PRESS_ERR_MAX);
    assign bus.warn = warn_r;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            warn_r <= 1'b0;
        end else begin
            warn_r <= warn_nxt;
        end
    end

    property p_press_warn_set;
        @(posedge clk) disable iff (!rst_b)
        (bus.pressure < 8'h23 || bus.pressure > 8'h32) |=> warn_r;
    endproperty
    a_press_warn_set: assert property (p_press_warn_set) else $error("pressure warning not set");

    property p_press_warn_hyst;
        @(posedge clk) disable iff (!rst_b)
        (warn_r && bus.pressure == 8'h24) |=> warn_r;
    endproperty
    a_press_warn_hyst: assert property (p_press_warn_hyst) else $error("pressure warning dropped in band");
endmodule // vtsi_press_mon

/* File: vtsi_status_image.sv */
// Cyclic input image of the vacuum terminal, read byte by byte
// Overview of operation
// - Error byte is read-only; each bit shows a fault active right now.
// - Error bit 0 shows internal data corruption.
// - Error bits 2 and 3 show primary voltage too low, too high.
// - Error bits 4 and 5 show secondary voltage too low, too high.
// - Error bit 6 shows supply pressure below 1.9 or above 6.3 bar.
// - Warning byte bits 0-3: voltages, pressure with 0.2 bar hysteresis, suction units.
// - Sixteen read-only status bytes, one per suction unit, same layout.
// - Status bit 0 shows the air-saving threshold reached.
// - Status bit 1 shows the part-present threshold reached.
// - Summed air consumption of all fitted units in litres per minute.
// - IO-Link port field carries the attached device's process data.
// - Digital-input port field carries the synchronised switching line state.
// - Eight port input fields: two masters of four ports.
// - Image layout: health 0, errors 1, warnings 2, units 3-18, air 19-22, ports 23.
// - Port process data bytes are kept in their received order.
// - Image is always 445 bytes long whatever is fitted.
`timescale 1ns/1ps
module vtsi_status_image (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic data_corrupt,
    input wire logic bus_fault,
    input wire logic pri_volt_low,
    input wire logic pri_volt_high,
    input wire logic sec_volt_low,
    input wire logic sec_volt_high,
    input wire logic pri_volt_limit,
    input wire logic sec_volt_limit,
    input wire logic maint_needed,
    input wire logic [7:0] supply_pressure_dbar,
    input wire logic [15:0] suction_fitted,
    input wire logic [15:0] air_saving_threshold,
    input wire logic [15:0] part_present_threshold,
    input wire logic [15:0] suction_unit_error,
    input wire logic [15:0][5:0] suction_unit_warning_flags,
    input wire logic [15:0][15:0] suction_air_lpm,
    input vtsi_pkg::vtsi_port_mode_e [7:0] port_mode,
    input wire logic [7:0] port_di_pin,
    input wire logic pd_wr,
    input wire logic [2:0] pd_port,
    input wire logic [4:0] pd_idx,
    input wire logic [7:0] pd_byte,
    input wire logic rd_req,
    input wire logic [8:0] rd_addr,
    output logic rd_valid,
    output logic [7:0] rd_data
);
    vtsi_press_if press_bus ();

    logic [7:0] health_r;
    logic [7:0] fault_r;
    logic [7:0] warn_r;
    logic [15:0][7:0] suct_r;
    logic [31:0] air_r;
    logic [7:0] pd_mem [0:7][0:31];
    logic [7:0] di_sync;
    logic [7:0] fault_nxt;
    logic [7:0] warn_nxt;
    logic [7:0] health_nxt;
    logic [15:0][7:0] suct_nxt;
    logic [15:0] suct_warn_any;
    logic [31:0] air_nxt;

    assign press_bus.pressure = supply_pressure_dbar;

    vtsi_press_mon u_press_mon (
        .clk(clk),
        .rst_b(rst_b),
        .bus(press_bus.mon)
    );

    vtsi_sync #(
        .W(8)
    ) u_di_sync (
        .clk(clk),
        .rst_b(rst_b),
        .d(port_di_pin),
        .q(di_sync)
    );

    // Per suction unit status byte; absent units read zero
    genvar i;
    generate
        for (i = 0; i < 16; i++) begin : g_suct
            assign suct_nxt[i][vtsi_pkg::ST_AIR_SAVE] = suction_fitted[i] & air_saving_threshold[i];
            assign suct_nxt[i][vtsi_pkg::ST_PART] = suction_fitted[i] & part_present_threshold[i];
            assign suct_nxt[i][7:2] = suction_fitted[i] ? suction_unit_warning_flags[i] : 6'h00;
            assign suct_warn_any[i] = suction_fitted[i] & (|suction_unit_warning_flags[i]);
        end
    endgenerate

    assign fault_nxt[vtsi_pkg::FLT_CORRUPT] = data_corrupt;
    assign fault_nxt[vtsi_pkg::FLT_BUS] = bus_fault;
    assign fault_nxt[vtsi_pkg::FLT_PRI_LO] = pri_volt_low;
    assign fault_nxt[vtsi_pkg::FLT_PRI_HI] = pri_volt_high;
    assign fault_nxt[vtsi_pkg::FLT_SEC_LO] = sec_volt_low;
    assign fault_nxt[vtsi_pkg::FLT_SEC_HI] = sec_volt_high;
    assign fault_nxt[vtsi_pkg::FLT_PRESS] = press_bus.err;
    assign fault_nxt[vtsi_pkg::FLT_SUCT] = |(suction_unit_error & suction_fitted);

    assign warn_nxt[vtsi_pkg::WRN_PRI] = pri_volt_limit;
    assign warn_nxt[vtsi_pkg::WRN_SEC] = sec_volt_limit;
    assign warn_nxt[vtsi_pkg::WRN_PRESS] = press_bus.warn;
    assign warn_nxt[vtsi_pkg::WRN_SUCT] = |suct_warn_any;
    assign warn_nxt[7:4] = 4'h0;

    // Traffic light: any fault or warning beats maintenance
    wire [1:0] light_code = ((|fault_nxt) || (|warn_nxt)) ? vtsi_pkg::HL_WARN :
                            (maint_needed ? vtsi_pkg::HL_MAINT : vtsi_pkg::HL_OPTIMAL);
    assign health_nxt = {light_code, 6'h00};

    // Summed consumption of fitted units
    always_comb begin
        air_nxt = vtsi_pkg::AIR_RST;
        for (int k = 0; k < 16; k++) begin
            if (suction_fitted[k]) begin
                air_nxt = air_nxt + 32'(suction_air_lpm[k]);
            end
        end
    end

    // Live status registers, refreshed every cycle
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            health_r <= vtsi_pkg::BYTE_RST;
            fault_r <= vtsi_pkg::BYTE_RST;
            warn_r <= vtsi_pkg::BYTE_RST;
            suct_r <= '0;
            air_r <= vtsi_pkg::AIR_RST;
        end else begin
            health_r <= health_nxt;
            fault_r <= fault_nxt;
            warn_r <= warn_nxt;
            suct_r <= suct_nxt;
            air_r <= air_nxt;
        end
    end

    // Port process data store, written only in IO-Link mode
    wire pd_take = pd_wr && (port_mode[pd_port] == vtsi_pkg::PM_IOLINK);

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            for (int p = 0; p < 8; p++) begin
                for (int b = 0; b < 32; b++) begin
                    pd_mem[p][b] <= vtsi_pkg::BYTE_RST;
                end
            end
        end else if (pd_take) begin
            pd_mem[pd_port][pd_idx] <= pd_byte;
        end
    end

    // Read address decode
    wire [8:0] suct_ofs = rd_addr - vtsi_pkg::OFS_SUCT;
    wire [8:0] air_ofs = rd_addr - vtsi_pkg::OFS_AIR;
    wire [8:0] port_ofs = rd_addr - vtsi_pkg::OFS_PORT;
    wire in_suct = (rd_addr >= vtsi_pkg::OFS_SUCT) && (rd_addr < vtsi_pkg::OFS_AIR);
    wire in_air = (rd_addr >= vtsi_pkg::OFS_AIR) && (rd_addr < vtsi_pkg::OFS_PORT);
    wire in_port = (rd_addr >= vtsi_pkg::OFS_PORT) && (rd_addr < vtsi_pkg::OFS_PORT_END);
    wire [2:0] port_sel = port_ofs[7:5];
    wire [4:0] byte_sel = port_ofs[4:0];
    wire [3:0] suct_sel = suct_ofs[3:0];
    wire [1:0] air_sel = air_ofs[1:0];
    wire sel_iolink = (port_mode[port_sel] == vtsi_pkg::PM_IOLINK);
    wire sel_di = (port_mode[port_sel] == vtsi_pkg::PM_DI);

    // Port field: IO-Link data, or the pin state in byte 0
    wire [7:0] port_byte = sel_iolink ? pd_mem[port_sel][byte_sel] :
                           ((sel_di && byte_sel == 5'h00) ? {7'h00, di_sync[port_sel]} :
                            vtsi_pkg::BYTE_RST);
    wire [7:0] air_byte = (air_sel == 2'h0) ? air_r[7:0] :
                          (air_sel == 2'h1) ? air_r[15:8] :
                          (air_sel == 2'h2) ? air_r[23:16] : air_r[31:24];

    // Bytes above the covered range up to the image end read zero
    wire [7:0] rd_byte = (rd_addr == vtsi_pkg::OFS_HEALTH) ? health_r :
                         (rd_addr == vtsi_pkg::OFS_FAULT) ? fault_r :
                         (rd_addr == vtsi_pkg::OFS_WARN) ? warn_r :
                         in_suct ? suct_r[suct_sel] :
                         in_air ? air_byte :
                         in_port ? port_byte : vtsi_pkg::BYTE_RST;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rd_valid <= 1'b0;
            rd_data <= vtsi_pkg::BYTE_RST;
        end else begin
            rd_valid <= rd_req;
            if (rd_req) begin
                rd_data <= rd_byte;
            end
        end
    end

    property p_rd_answer;
        @(posedge clk) disable iff (!rst_b)
        rd_req |=> rd_valid;
    endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("read not answered next cycle");

    property p_press_fault;
        @(posedge clk) disable iff (!rst_b)
        1'b1 |=> (fault_r[6] == ($past(supply_pressure_dbar) < 8'h13 || $past(supply_pressure_dbar) > 8'h3f));
    endproperty
    a_press_fault: assert property (p_press_fault) else $error("pressure error bit wrong");

    property p_suct_fault;
        @(posedge clk) disable iff (!rst_b)
        1'b1 |=> (fault_r[7] == (|($past(suction_unit_error) & $past(suction_fitted))));
    endproperty
    a_suct_fault: assert property (p_suct_fault) else $error("unit error summary wrong");

    property p_air_save;
        @(posedge clk) disable iff (!rst_b)
        (suction_fitted[0] && air_saving_threshold[0] && !part_present_threshold[0]) |=> (suct_r[0][1:0] == 2'h1);
    endproperty
    a_air_save: assert property (p_air_save) else $error("air-saving bit not shown");

    property p_warn_reserved;
        @(posedge clk) disable iff (!rst_b)
        (rd_req && rd_addr == 9'h002) |=> (rd_data[7:4] == 4'h0);
    endproperty
    a_warn_reserved: assert property (p_warn_reserved) else $error("reserved warning bits set");

    property p_img_tail;
        @(posedge clk) disable iff (!rst_b)
        (rd_req && rd_addr >= 9'h117) |=> (rd_data == 8'h00);
    endproperty
    a_img_tail: assert property (p_img_tail) else $error("uncovered image byte not zero");

    property p_di_field;
        @(posedge clk) disable iff (!rst_b)
        (rd_req && rd_addr == 9'h017 && port_mode[0] == vtsi_pkg::PM_DI) |=> (rd_data == {7'h00, $past(di_sync[0])});
    endproperty
    a_di_field: assert property (p_di_field) else $error("digital input field wrong");

    property p_health_warn;
        @(posedge clk) disable iff (!rst_b)
        ((|fault_r) || (|warn_r)) |-> (health_r[7:6] == 2'h2 && health_r[5:0] == 6'h00);
    endproperty
    a_health_warn: assert property (p_health_warn) else $error("health code not warning");

    property p_health_calm;
        @(posedge clk) disable iff (!rst_b)
        (fault_r == 8'h00 && warn_r == 8'h00) |-> (health_r == {($past(maint_needed) ? 2'h1 : 2'h0), 6'h00});
    endproperty
    a_health_calm: assert property (p_health_calm) else $error("health code without warning wrong");

    property p_corrupt_fault;
        @(posedge clk) disable iff (!rst_b)
        1'b1 |=> (fault_r[0] == $past(data_corrupt));
    endproperty
    a_corrupt_fault: assert property (p_corrupt_fault) else $error("corruption error bit wrong");

    property p_bus_fault;
        @(posedge clk) disable iff (!rst_b)
        1'b1 |=> (fault_r[1] == $past(bus_fault));
    endproperty
    a_bus_fault: assert property (p_bus_fault) else $error("bus fault error bit wrong");

    property p_pri_fault;
        @(posedge clk) disable iff (!rst_b)
        1'b1 |=> (fault_r[3:2] == {$past(pri_volt_high), $past(pri_volt_low)});
    endproperty
    a_pri_fault: assert property (p_pri_fault) else $error("primary voltage error bits wrong");

    property p_sec_fault;
        @(posedge clk) disable iff (!rst_b)
        1'b1 |=> (fault_r[5:4] == {$past(sec_volt_high), $past(sec_volt_low)});
    endproperty
    a_sec_fault: assert property (p_sec_fault) else $error("secondary voltage error bits wrong");

    property p_volt_warn;
        @(posedge clk) disable iff (!rst_b)
        1'b1 |=> (warn_r[1:0] == {$past(sec_volt_limit), $past(pri_volt_limit)});
    endproperty
    a_volt_warn: assert property (p_volt_warn) else $error("voltage warning bits wrong");

    property p_part_present;
        @(posedge clk) disable iff (!rst_b)
        (suction_fitted[14] && part_present_threshold[14]) |=> suct_r[14][1];
    endproperty
    a_part_present: assert property (p_part_present) else $error("part-present bit not shown");

    property p_unit_flags;
        @(posedge clk) disable iff (!rst_b)
        suction_fitted[14] |=> (suct_r[14][7:2] == $past(suction_unit_warning_flags[14]));
    endproperty
    a_unit_flags: assert property (p_unit_flags) else $error("unit monitoring flags wrong");

    property p_unit_absent;
        @(posedge clk) disable iff (!rst_b)
        !suction_fitted[15] |=> (suct_r[15] == 8'h00);
    endproperty
    a_unit_absent: assert property (p_unit_absent) else $error("absent unit status not zero");

    property p_air_lsb;
        @(posedge clk) disable iff (!rst_b)
        (rd_req && rd_addr == 9'h013) |=> (rd_data == $past(air_r[7:0]));
    endproperty
    a_air_lsb: assert property (p_air_lsb) else $error("air total low byte misplaced");

    property p_pd_store;
        @(posedge clk) disable iff (!rst_b)
        (pd_wr && pd_port == 3'h7 && pd_idx == 5'h00 && port_mode[7] == vtsi_pkg::PM_IOLINK) |=>
            (pd_mem[7][0] == $past(pd_byte));
    endproperty
    a_pd_store: assert property (p_pd_store) else $error("port data byte not stored unaltered");

    property p_port_idle;
        @(posedge clk) disable iff (!rst_b)
        (rd_req && rd_addr == 9'h037 && port_mode[1] != vtsi_pkg::PM_IOLINK && port_mode[1] != vtsi_pkg::PM_DI) |=>
            (rd_data == 8'h00);
    endproperty
    a_port_idle: assert property (p_port_idle) else $error("port field without input mode not zero");
endmodule // vtsi_status_image

/* File: vtsi_ctrl_model.sv */
// Fieldbus controller model reading the cyclic input image
`timescale 1ns/1ps
module vtsi_ctrl_model (
    input wire logic clk,
    output logic rd_req,
    output logic [8:0] rd_addr,
    input wire logic rd_valid,
    input wire logic [7:0] rd_data
);
    initial begin
        rd_req = 1'b0;
        rd_addr = 9'h000;
    end
    // One request pulse, answer taken while rd_valid stands
    task automatic read(input logic [8:0] addr, output logic [7:0] data, output bit ok);
        ok = 1'b0;
        data = 8'h00;
        @(negedge clk);
        rd_req = 1'b1;
        rd_addr = addr;
        @(negedge clk);
        rd_req = 1'b0;
        rd_addr = ~addr;
        for (int n = 0; n < 4 && !ok; n++) begin
            if (rd_valid === 1'b1) begin
                data = rd_data;
                ok = 1'b1;
            end else begin
                @(negedge clk);
            end
        end
    endtask
endmodule // vtsi_ctrl_model

/* File: vtsi_status_image_bench.sv */
// Self-checking bench of the vacuum terminal status image
`timescale 1ns/1ps
module vtsi_status_image_bench;
    logic clk, rst_b, data_corrupt, bus_fault, pri_volt_low, pri_volt_high, sec_volt_low, sec_volt_high;
    logic pri_volt_limit, sec_volt_limit, maint_needed, pd_wr, rd_req, rd_valid;
    logic [7:0] supply_pressure_dbar, port_di_pin, pd_byte, rd_data;
    logic [15:0] suction_fitted, air_saving_threshold, part_present_threshold, suction_unit_error;
    logic [15:0][5:0] suction_unit_warning_flags;
    logic [15:0][15:0] suction_air_lpm;
    vtsi_pkg::vtsi_port_mode_e [7:0] port_mode;
    logic [2:0] pd_port;
    logic [4:0] pd_idx;
    logic [8:0] rd_addr;
    int failures = 0;
    int n_compared = 0;
    logic [7:0] ptab [10] = '{8'h13, 8'h3f, 8'h40, 8'h28, 8'h22, 8'h24, 8'h25, 8'h31, 8'h33, 8'h30};
    logic [9:0] etab = 10'b0000000100;
    logic [9:0] wtab = 10'b0100110111;
    logic [31:0] air_sum;

    vtsi_status_image dut (.clk(clk), .rst_b(rst_b), .data_corrupt(data_corrupt), .bus_fault(bus_fault),
        .pri_volt_low(pri_volt_low), .pri_volt_high(pri_volt_high), .sec_volt_low(sec_volt_low),
        .sec_volt_high(sec_volt_high), .pri_volt_limit(pri_volt_limit), .sec_volt_limit(sec_volt_limit),
        .maint_needed(maint_needed), .supply_pressure_dbar(supply_pressure_dbar), .suction_fitted(suction_fitted),
        .air_saving_threshold(air_saving_threshold), .part_present_threshold(part_present_threshold),
        .suction_unit_error(suction_unit_error), .suction_unit_warning_flags(suction_unit_warning_flags),
        .suction_air_lpm(suction_air_lpm), .port_mode(port_mode), .port_di_pin(port_di_pin), .pd_wr(pd_wr),
        .pd_port(pd_port), .pd_idx(pd_idx), .pd_byte(pd_byte), .rd_req(rd_req), .rd_addr(rd_addr),
        .rd_valid(rd_valid), .rd_data(rd_data));
    vtsi_ctrl_model ctrl (.clk(clk), .rd_req(rd_req), .rd_addr(rd_addr), .rd_valid(rd_valid), .rd_data(rd_data));

    task automatic close_out();
        $display("compared %0d, failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic rd_chk(input string what, input logic [8:0] a, input logic [7:0] exp);
        logic [7:0] d;
        bit ok;
        ctrl.read(a, d, ok);
        if (!ok) begin
            failures++;
            $display("CHECK FAILED %s expected answer seen none", what);
            close_out();
        end else begin
            chk(what, exp, d);
        end
    endtask
    task automatic settle();
        repeat (4) @(negedge clk);
    endtask
    task automatic drive_fault(input int b, input logic v);
        case (b)
            0: data_corrupt = v;
            1: bus_fault = v;
            2: pri_volt_low = v;
            3: pri_volt_high = v;
            4: sec_volt_low = v;
            5: sec_volt_high = v;
            6: supply_pressure_dbar = v ? 8'h12 : 8'h28;
            default: suction_unit_error[5] = v;
        endcase
    endtask
    task automatic pd_put(input logic [2:0] p, input logic [4:0] i, input logic [7:0] d);
        pd_wr = 1'b1;
        pd_port = p;
        pd_idx = i;
        pd_byte = d;
        @(negedge clk);
    endtask

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial begin
        #200000;
        failures++;
        $display("CHECK FAILED run time expected end seen limit");
        close_out();
    end
    initial begin
        {data_corrupt, bus_fault, pri_volt_low, pri_volt_high, sec_volt_low, sec_volt_high} = 6'h00;
        {pri_volt_limit, sec_volt_limit, maint_needed, pd_wr} = 4'h0;
        supply_pressure_dbar = 8'h28;
        {port_di_pin, pd_byte, pd_port, pd_idx} = 24'h000000;
        {suction_fitted, air_saving_threshold, part_present_threshold, suction_unit_error} = 64'h0;
        suction_unit_warning_flags = '0;
        suction_air_lpm = '0;
        port_mode = {8{vtsi_pkg::PM_OFF}};
        rst_b = 1'b0;
        repeat (6) @(negedge clk);
        rst_b = 1'b1;
        settle();
        rd_chk("health", vtsi_pkg::OFS_HEALTH, 8'h00);
        rd_chk("fault_flags", vtsi_pkg::OFS_FAULT, 8'h00);
        rd_chk("last_byte", 9'h1bc, 8'h00);
        $display("test reset done");
        suction_fitted = 16'hffff;
        for (int b = 0; b < 8; b++) begin
            drive_fault(b, 1'b1);
            settle();
            rd_chk("fault_flags", vtsi_pkg::OFS_FAULT, 8'h01 << b);
            rd_chk("health", vtsi_pkg::OFS_HEALTH, {vtsi_pkg::HL_WARN, 6'h00});
            drive_fault(b, 1'b0);
        end
        {pri_volt_limit, sec_volt_limit} = 2'b11;
        settle();
        rd_chk("warning_flags", vtsi_pkg::OFS_WARN, 8'h03);
        {pri_volt_limit, sec_volt_limit} = 2'b00;
        $display("test faults done");
        for (int i = 0; i < 10; i++) begin
            supply_pressure_dbar = ptab[i];
            settle();
            rd_chk("fault_flags", vtsi_pkg::OFS_FAULT, {1'b0, etab[i], 6'h00});
            rd_chk("warning_flags", vtsi_pkg::OFS_WARN, {5'h00, wtab[i], 2'b00});
        end
        supply_pressure_dbar = 8'h28;
        $display("test pressure done");
        suction_fitted = 16'h7fff;
        air_saving_threshold = 16'h8001;
        part_present_threshold = 16'hc000;
        suction_unit_error = 16'h8000;
        suction_unit_warning_flags[14] = 6'h2a;
        suction_unit_warning_flags[15] = 6'h3f;
        suction_air_lpm[0] = 16'hfff0;
        suction_air_lpm[14] = 16'h0123;
        suction_air_lpm[15] = 16'h5555;
        air_sum = 32'h0001_0113;
        settle();
        rd_chk("unit_0", vtsi_pkg::OFS_SUCT, 8'h01);
        rd_chk("unit_14", vtsi_pkg::OFS_SUCT + 9'h00e, 8'haa);
        rd_chk("unit_15", vtsi_pkg::OFS_SUCT + 9'h00f, 8'h00);
        rd_chk("fault_flags", vtsi_pkg::OFS_FAULT, 8'h00);
        rd_chk("warning_flags", vtsi_pkg::OFS_WARN, 8'h08);
        for (int k = 0; k < 4; k++) begin
            rd_chk("air", vtsi_pkg::OFS_AIR + 9'(k), air_sum[8*k +: 8]);
        end
        suction_unit_warning_flags = '0;
        maint_needed = 1'b1;
        settle();
        rd_chk("health", vtsi_pkg::OFS_HEALTH, {vtsi_pkg::HL_MAINT, 6'h00});
        maint_needed = 1'b0;
        $display("test units done");
        port_mode[7] = vtsi_pkg::PM_IOLINK;
        port_mode[0] = vtsi_pkg::PM_DI;
        port_mode[1] = vtsi_pkg::PM_DO;
        port_di_pin = 8'h03;
        @(negedge clk);
        pd_put(3'h7, 5'h00, 8'ha5);
        pd_put(3'h7, 5'h1f, 8'h3c);
        pd_put(3'h1, 5'h00, 8'h77);
        pd_wr = 1'b0;
        settle();
        rd_chk("port_7_first", 9'h0f7, 8'ha5);
        rd_chk("port_7_last", 9'h116, 8'h3c);
        rd_chk("port_0_di", vtsi_pkg::OFS_PORT, 8'h01);
        rd_chk("port_0_rest", vtsi_pkg::OFS_PORT + 9'h001, 8'h00);
        rd_chk("port_1_do", 9'h037, 8'h00);
        port_mode[1] = vtsi_pkg::PM_IOLINK;
        settle();
        rd_chk("port_1_dropped", 9'h037, 8'h00);
        rd_chk("beyond_ports", 9'h117, 8'h00);
        $display("test ports done");
        close_out();
    end
endmodule // vtsi_status_image_bench
